// ---- pkg/usbnr_pkg.sv ----
package usbnr_pkg;

   // Clock and bus timing, kept in nanoseconds as printed.
   localparam int unsigned CLK_PERIOD_NS        = 4;
   localparam int unsigned SUSPEND_IDLE_NS      = 3_000_000;
   localparam int unsigned BUS_RESET_SE0_NS     = 2_500;
   // Least times round up to whole clock cycles.
   localparam int unsigned SUSPEND_IDLE_CYCLES  = (SUSPEND_IDLE_NS + CLK_PERIOD_NS - 1) /
                                                  CLK_PERIOD_NS;
   localparam int unsigned BUS_RESET_SE0_CYCLES = (BUS_RESET_SE0_NS + CLK_PERIOD_NS - 1) /
                                                  CLK_PERIOD_NS;

   localparam int unsigned NUM_EP      = 8;
   localparam int unsigned NUM_FACTORS = 7;

   // Register indices; the APB byte address is four times the index.
   localparam logic [7:0] IDX_EP_IRQ_EN [NUM_EP] = '{8'h98, 8'h99, 8'h9A, 8'h9B,
                                                     8'h9C, 8'h9D, 8'h9E, 8'h9F};
   localparam logic [7:0] IDX_XCVR_RESET  = 8'hA0;
   localparam logic [7:0] IDX_EVENT_FLAGS = 8'hA1;
   localparam logic [7:0] IDX_NEGO_CTRL   = 8'hA2;
   localparam logic [7:0] IDX_EP_SUMMARY  = 8'hA6;

   // Enable field positions inside each endpoint enable register.
   localparam int unsigned OUT_SHORT_ACK_IRQ_EN_BIT = 6;
   localparam int unsigned IN_ACK_IRQ_EN_BIT        = 5;
   localparam int unsigned OUT_ACK_IRQ_EN_BIT       = 4;
   localparam int unsigned IN_NAK_IRQ_EN_BIT        = 3;
   localparam int unsigned OUT_NAK_IRQ_EN_BIT       = 2;
   localparam int unsigned IN_ERROR_IRQ_EN_BIT      = 1;
   localparam int unsigned OUT_ERROR_IRQ_EN_BIT     = 0;

   // Negotiation control fields.
   localparam int unsigned BUS_WATCH_DISABLE_BIT   = 7;
   localparam int unsigned AUTO_NEGO_ENABLE_BIT    = 6;
   localparam int unsigned SUSPENDED_FLAG_BIT      = 5;
   localparam int unsigned HIGH_SPEED_DISABLE_BIT  = 4;
   localparam int unsigned REMOTE_WAKE_SIGNAL_BIT  = 3;
   localparam int unsigned RESUME_RESTORE_BIT      = 2;
   localparam int unsigned CHIRP_START_BIT         = 1;
   localparam int unsigned CONTROLLER_ACTIVATE_BIT = 0;

   localparam int unsigned XCVR_MACRO_RESET_BIT_POS = 0;

   // Event flag fields, write one to clear.
   localparam int unsigned CHIRP_DONE_IRQ_BIT       = 0;
   localparam int unsigned BUS_RESET_SEEN_IRQ_BIT   = 1;
   localparam int unsigned BUS_SUSPEND_SEEN_IRQ_BIT = 2;
   localparam int unsigned RESTORE_DONE_IRQ_BIT     = 3;

   // Reset values.
   localparam logic [6:0] EP_IRQ_EN_RESET   = 7'h00;
   localparam logic       XCVR_RESET_RESET  = 1'h1;
   localparam logic [7:0] NEGO_CTRL_RESET   = 8'h00;
   localparam logic [3:0] EVENT_FLAGS_RESET = 4'h0;

   // Bus watcher states, one bit apart from the watching state.
   typedef enum logic [1:0] {
      WATCH_LINE      = 2'b00,
      WATCH_BUS_RESET = 2'b01,
      WATCH_SUSPENDED = 2'b10
   } usbnr_watch_type;

endpackage

// ---- pkg/usbnr_reg_if.sv ----
`timescale 1ns/1ps
// Register access path from the APB front end to the register bank.
interface usbnr_reg_if;
   logic       wr;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       hit;

   modport front (output wr, output idx, output wdata, input rdata, input hit);
   modport bank  (input wr, input idx, input wdata, output rdata, output hit);
endinterface

// ---- design/usbnr_apb_slave.sv ----
`timescale 1ns/1ps
module usbnr_apb_slave
   import usbnr_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   usbnr_reg_if.front             regs
);
   if (ADDR_W < 10) begin : g_bad_width
      $error("usbnr_apb_slave needs at least ten address bits");
   end

   typedef struct packed {
      logic [31:0] rdata;
      logic        ready;
      logic        err;
   } usbnr_apb_state_type;

   usbnr_apb_state_type st_q;
   usbnr_apb_state_type st_d;
   logic                aligned;

   // Only whole aligned words inside the index range decode.
   always_comb begin
      aligned = (paddr[1:0] == 2'h0);
      if (ADDR_W > 10) begin
         aligned = aligned && (paddr >> 10) == '0;
      end
   end

   assign regs.idx   = paddr[9:2];
   assign regs.wdata = pwdata[7:0];
   // The write lands on the edge where the access phase completes.
   assign regs.wr    = psel && penable && pwrite && st_q.ready && !st_q.err;

   // Every transfer answers in its first access cycle; read data is caught at setup.
   always_comb begin
      st_d       = st_q;
      st_d.ready = 1'h0;
      st_d.err   = 1'h0;
      st_d.rdata = 32'h00000000;
      if (psel && !penable) begin
         st_d.ready = 1'h1;
         st_d.err   = !(aligned && regs.hit);
         st_d.rdata = (aligned && regs.hit && !pwrite) ? {24'h000000, regs.rdata} : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata  = st_q.rdata;
   assign pready  = st_q.ready;
   assign pslverr = st_q.err;
endmodule

// ---- design/usbnr_ep_summary.sv ----
`timescale 1ns/1ps
module usbnr_ep_summary
   import usbnr_pkg::*;
#(
   parameter int unsigned EPS = NUM_EP
) (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic [EPS-1:0][NUM_FACTORS-1:0] events,
   input  wire logic [EPS-1:0][NUM_FACTORS-1:0] enables,
   output logic [EPS-1:0]                        summary
);
   typedef struct packed {
      logic [EPS-1:0] summary;
   } usbnr_sum_state_type;

   usbnr_sum_state_type st_q;
   usbnr_sum_state_type st_d;
   logic [EPS-1:0]      gated;

   // Each endpoint bit is the OR of its factors, each masked by its enable.
   for (genvar i = 0; i < EPS; i++) begin : g_ep
      assign gated[i] = |(events[i] & enables[i]);
   end

   always_comb begin
      st_d         = st_q;
      st_d.summary = gated;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign summary = st_q.summary;

   chk_masked_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      (enables[0] == '0) |=> !summary[0])
      else $error("Endpoint summary rose with every enable clear.");

   chk_summary_tracks: assert property (
      @(posedge pclk) disable iff (!presetn)
      ((events[EPS-1] & enables[EPS-1]) != '0) |=> summary[EPS-1])
      else $error("Enabled endpoint factor did not reach the summary.");
endmodule

// ---- design/usbnr_regs.sv ----
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module usbnr_regs
   import usbnr_pkg::*;
#(
   parameter int unsigned ADDR_W       = 12,
   parameter int unsigned IDLE_CYCLES  = SUSPEND_IDLE_CYCLES,
   parameter int unsigned SE0_CYCLES   = BUS_RESET_SE0_CYCLES
) (
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [ADDR_W-1:0]                   paddr,
   input  wire logic [31:0]                         pwdata,
   output logic [31:0]                              prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic [NUM_EP-1:0][NUM_FACTORS-1:0]  endpoint_event_status,
   input  wire logic                                low_power_doze_state,
   input  wire logic                                line_active,
   input  wire logic                                line_se0,
   input  wire logic                                chirp_done_in,
   input  wire logic                                chirp_hs_result,
   output logic [NUM_EP-1:0]                        endpoint_summary_irq_status,
   output logic                                     xcvr_macro_reset_bit,
   output logic                                     controller_activate,
   output logic                                     auto_speed_negotiation_enable,
   output logic                                     remote_wake_signal,
   output logic                                     chirp_go,
   output logic                                     hs_mode
);
   localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);
   localparam int unsigned SW = $clog2(SE0_CYCLES + 1);

   if (IDLE_CYCLES < 1 || SE0_CYCLES < 1 || IDLE_CYCLES > 32'h00FFFFFF) begin : g_bad_count
      $error("usbnr_regs timing counts are out of range");
   end

   typedef struct packed {
      logic [NUM_EP-1:0][NUM_FACTORS-1:0] ep_en;
      logic                               xcvr_rst;
      logic [7:0]                         nego;
      logic [3:0]                         flags;
      logic                               hs;
      logic                               hs_saved;
      logic                               chirp_go;
      usbnr_watch_type                    watch;
      logic [IW-1:0]                      idle_cnt;
      logic [SW-1:0]                      se0_cnt;
   } usbnr_regs_state_type;

   usbnr_regs_state_type st_q;
   usbnr_regs_state_type st_d;
   usbnr_reg_if          bus ();
   logic                 ep_hit;
   logic [2:0]           ep_sel;
   logic                 watching;
   logic                 chirp_in_reset;
   logic [3:0]           flag_set;
   logic                 open_access;

   usbnr_apb_slave #(
      .ADDR_W (ADDR_W)
   ) u_apb (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .regs    (bus.front)
   );

   usbnr_ep_summary #(
      .EPS (NUM_EP)
   ) u_summary (
      .pclk    (pclk),
      .presetn (presetn),
      .events  (endpoint_event_status),
      .enables (st_q.ep_en),
      .summary (endpoint_summary_irq_status)
   );

   // Find which endpoint enable register, if any, the index names.
   always_comb begin
      ep_hit = 1'h0;
      ep_sel = 3'h0;
      for (int i = 0; i < NUM_EP; i++) begin
         if (bus.idx == IDX_EP_IRQ_EN[i]) begin
            ep_hit = 1'h1;
            ep_sel = i[2:0];
         end
      end
   end

   // Only the transceiver reset register stays reachable in low power, since
   // the rest of the bank sits in a domain that may be gated then.
   assign open_access = !low_power_doze_state;

   // Read mux; everything beyond the transceiver reset reads zero in low power.
   always_comb begin
      bus.rdata = 8'h00;
      bus.hit   = 1'h1;
      if (bus.idx == IDX_XCVR_RESET) begin
         bus.rdata = {7'h00, st_q.xcvr_rst};
      end else if (bus.idx == IDX_NEGO_CTRL) begin
         bus.rdata = open_access ? st_q.nego : 8'h00;
      end else if (bus.idx == IDX_EVENT_FLAGS) begin
         bus.rdata = open_access ? {4'h0, st_q.flags} : 8'h00;
      end else if (bus.idx == IDX_EP_SUMMARY) begin
         bus.rdata = open_access ? endpoint_summary_irq_status : 8'h00;
      end else if (ep_hit) begin
         bus.rdata = open_access ? {1'h0, st_q.ep_en[ep_sel]} : 8'h00;
      end else begin
         bus.hit = 1'h0;
      end
   end

   assign watching       = st_q.nego[CONTROLLER_ACTIVATE_BIT] &&
                           !st_q.nego[BUS_WATCH_DISABLE_BIT];
   assign chirp_in_reset = st_q.nego[CHIRP_START_BIT] && st_q.watch == WATCH_BUS_RESET;

   // Next state: register writes, bus watcher, chirp and restore sequencing.
   always_comb begin
      st_d     = st_q;
      flag_set = 4'h0;

      // Software writes; hardware-owned self-clearing bits follow below so
      // that completion always wins over a stale write.
      if (bus.wr) begin
         if (bus.idx == IDX_XCVR_RESET) begin
            st_d.xcvr_rst = bus.wdata[XCVR_MACRO_RESET_BIT_POS];
         end else if (!open_access) begin
            st_d.xcvr_rst = st_q.xcvr_rst;
         end else if (bus.idx == IDX_NEGO_CTRL) begin
            st_d.nego = bus.wdata;
         end else if (bus.idx == IDX_EVENT_FLAGS) begin
            st_d.flags = st_q.flags & ~bus.wdata[3:0];
         end else if (ep_hit) begin
            st_d.ep_en[ep_sel] = bus.wdata[NUM_FACTORS-1:0];
         end
      end

      // Bus watcher runs only while the controller is active and not disabled.
      if (!watching) begin
         st_d.watch    = WATCH_LINE;
         st_d.idle_cnt = '0;
         st_d.se0_cnt  = '0;
      end else begin
         case (st_q.watch)
            WATCH_LINE: begin
               st_d.idle_cnt = line_active ? '0 : st_q.idle_cnt + 1'b1;
               st_d.se0_cnt  = (line_se0 && !st_q.hs) ? st_q.se0_cnt + 1'b1 : '0;
               if (line_se0 && !st_q.hs && st_q.se0_cnt == SW'(SE0_CYCLES - 1)) begin
                  flag_set[BUS_RESET_SEEN_IRQ_BIT] = 1'h1;
                  st_d.watch    = WATCH_BUS_RESET;
                  st_d.idle_cnt = '0;
               end else if (!line_active && st_q.idle_cnt == IW'(IDLE_CYCLES - 1)) begin
                  st_d.idle_cnt = '0;
                  if (st_q.hs) begin
                     // High speed idle cannot tell reset from suspend, so
                     // fall back to full speed and watch once more.
                     st_d.hs = 1'h0;
                  end else begin
                     flag_set[BUS_SUSPEND_SEEN_IRQ_BIT] = 1'h1;
                     st_d.watch = WATCH_SUSPENDED;
                     if (st_q.nego[AUTO_NEGO_ENABLE_BIT]) begin
                        st_d.nego[SUSPENDED_FLAG_BIT] = 1'h1;
                     end
                  end
               end
            end
            WATCH_BUS_RESET: begin
               st_d.se0_cnt = '0;
               if (!line_se0) begin
                  st_d.watch = WATCH_LINE;
               end
            end
            WATCH_SUSPENDED: begin
               if (line_active) begin
                  st_d.watch = WATCH_LINE;
               end
            end
            default: begin
               st_d.watch = WATCH_LINE;
            end
         endcase
      end

      // Remember the speed on entry to suspend for a later restore.
      if (st_q.watch != WATCH_SUSPENDED && st_d.watch == WATCH_SUSPENDED) begin
         st_d.hs_saved = st_d.hs;
      end

      // Chirp: with high speed refused it finishes at once in full speed;
      // otherwise the handshake engine is asked and its answer ends it.
      st_d.chirp_go = 1'h0;
      if (chirp_in_reset) begin
         if (st_q.nego[HIGH_SPEED_DISABLE_BIT]) begin
            st_d.hs                    = 1'h0;
            st_d.nego[CHIRP_START_BIT] = 1'h0;
            flag_set[CHIRP_DONE_IRQ_BIT] = 1'h1;
         end else if (chirp_done_in && st_q.chirp_go) begin
            st_d.hs                    = chirp_hs_result;
            st_d.nego[CHIRP_START_BIT] = 1'h0;
            flag_set[CHIRP_DONE_IRQ_BIT] = 1'h1;
         end else begin
            st_d.chirp_go = 1'h1;
         end
      end

      // Restore brings back the saved speed in one step and self-clears.
      if (st_q.nego[RESUME_RESTORE_BIT]) begin
         st_d.hs                       = st_q.hs_saved;
         st_d.nego[RESUME_RESTORE_BIT] = 1'h0;
         flag_set[RESTORE_DONE_IRQ_BIT] = 1'h1;
      end

      // A new event beats a clear written in the same cycle.
      st_d.flags = st_d.flags | flag_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q          <= '0;
         st_q.ep_en    <= {NUM_EP{EP_IRQ_EN_RESET}};
         st_q.xcvr_rst <= XCVR_RESET_RESET;
         st_q.nego     <= NEGO_CTRL_RESET;
         st_q.flags    <= EVENT_FLAGS_RESET;
         st_q.watch    <= WATCH_LINE;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs come straight from the state flops.
   assign xcvr_macro_reset_bit          = st_q.xcvr_rst;
   assign controller_activate           = st_q.nego[CONTROLLER_ACTIVATE_BIT];
   assign auto_speed_negotiation_enable = st_q.nego[AUTO_NEGO_ENABLE_BIT];
   // Wake signalling length is timed by software; the block only drives it.
   assign remote_wake_signal            = st_q.nego[REMOTE_WAKE_SIGNAL_BIT];
   assign chirp_go                      = st_q.chirp_go;
   assign hs_mode                       = st_q.hs;

   chk_enable_reset_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> (st_q.ep_en == '0))
      else $error("Endpoint enables not zero after reset.");

   chk_enable_needs_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(st_q.ep_en) |-> $past(bus.wr) && $past(ep_hit))
      else $error("Endpoint enables changed without a write.");

   chk_xcvr_reset_one: assert property (
      @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> xcvr_macro_reset_bit)
      else $error("Transceiver not held in reset after reset.");

   chk_xcvr_write_one: assert property (
      @(posedge pclk) disable iff (!presetn)
      (bus.wr && bus.idx == IDX_XCVR_RESET && bus.wdata[0]) |=> xcvr_macro_reset_bit)
      else $error("Writing one did not hold the transceiver in reset.");

   chk_xcvr_doze_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (low_power_doze_state && bus.wr && bus.idx == IDX_XCVR_RESET && !bus.wdata[0])
      |=> !xcvr_macro_reset_bit)
      else $error("Transceiver reset write lost in low power.");

   chk_nego_reset_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> (st_q.nego == 8'h00) && !controller_activate)
      else $error("Negotiation control not zero after reset.");

   chk_idle_when_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      !controller_activate |=> st_q.watch == WATCH_LINE &&
      st_q.flags[1:1] == $past(st_q.flags[1:1]) || $past(bus.wr))
      else $error("Bus watcher acted while the controller was off.");

   chk_se0_bus_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      (watching && st_q.watch == WATCH_LINE && !st_q.hs && line_se0 &&
       st_q.se0_cnt == SW'(SE0_CYCLES - 1)) |=> st_q.watch == WATCH_BUS_RESET ##0 st_q.flags[1])
      else $error("Long SE0 did not raise bus reset.");

   chk_chirp_selfclear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (chirp_in_reset && st_q.nego[HIGH_SPEED_DISABLE_BIT])
      |=> !st_q.nego[CHIRP_START_BIT] && st_q.flags[0] && !hs_mode)
      else $error("Chirp with high speed refused did not finish.");

   chk_xcvr_write_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (bus.wr && bus.idx == IDX_XCVR_RESET && !bus.wdata[0]) |=> !xcvr_macro_reset_bit)
      else $error("Clearing the bit did not release the transceiver.");

   chk_hs_idle_drop: assert property (
      @(posedge pclk) disable iff (!presetn)
      (watching && st_q.watch == WATCH_LINE && st_q.hs && !line_active &&
       st_q.idle_cnt == IW'(IDLE_CYCLES - 1) && !st_q.nego[RESUME_RESTORE_BIT])
      |=> !hs_mode)
      else $error("Long idle in high speed did not fall back to full speed.");

   chk_idle_suspend: assert property (
      @(posedge pclk) disable iff (!presetn)
      (watching && st_q.watch == WATCH_LINE && !st_q.hs && !line_active && !line_se0 &&
       st_q.idle_cnt == IW'(IDLE_CYCLES - 1)) |=> st_q.flags[BUS_SUSPEND_SEEN_IRQ_BIT])
      else $error("Long idle in full speed did not raise suspend.");

   chk_chirp_handshake: assert property (
      @(posedge pclk) disable iff (!presetn)
      (chirp_in_reset && !st_q.nego[HIGH_SPEED_DISABLE_BIT] && chirp_done_in &&
       st_q.chirp_go && !st_q.nego[RESUME_RESTORE_BIT])
      |=> hs_mode == $past(chirp_hs_result) && !st_q.nego[CHIRP_START_BIT] && st_q.flags[0])
      else $error("Finished handshake did not set the speed and self-clear.");

   cov_bus_reset: cover property (@(posedge pclk) disable iff (!presetn)
      st_q.watch == WATCH_BUS_RESET);
   cov_suspend: cover property (@(posedge pclk) disable iff (!presetn)
      st_q.watch == WATCH_SUSPENDED);
   cov_chirp_done: cover property (@(posedge pclk) disable iff (!presetn)
      chirp_done_in && st_q.chirp_go);
   cov_summary: cover property (@(posedge pclk) disable iff (!presetn)
      endpoint_summary_irq_status != '0);
   cov_chirp_refused: cover property (@(posedge pclk) disable iff (!presetn)
      chirp_in_reset && st_q.nego[HIGH_SPEED_DISABLE_BIT]);
endmodule

// ---- testbench/usbnr_host_model.sv ----
`timescale 1ns/1ps
// Host beyond the transceiver: drives line states and answers the speed handshake.
module usbnr_host_model (
   input  wire logic       pclk,
   input  wire logic [1:0] bus_mode,
   input  wire logic       chirp_go,
   output logic            line_se0 = 1'b0,
   output logic            line_active = 1'b0,
   output logic            chirp_done_in = 1'b0,
   output logic            chirp_hs_result = 1'b0
);
   logic [1:0] wait_q = 2'h0;

   // The answer comes late on purpose, so the design must hold its request.
   always @(posedge pclk) begin
      line_se0 <= (bus_mode == 2'h1);
      line_active <= (bus_mode == 2'h2);
      chirp_hs_result <= 1'b1;
      chirp_done_in <= chirp_go && (wait_q == 2'h3);
      wait_q <= chirp_go ? wait_q + 2'h1 : 2'h0;
   end
endmodule

// ---- testbench/usbnr_regs_test.sv ----
`timescale 1ns/1ps
module usbnr_regs_test;
   import usbnr_pkg::*;
   typedef struct {int ep; logic [7:0] en; logic [6:0] ev; logic [7:0] sum;} usbnr_row_type;
   logic                           pclk = 1'b0;
   logic                           presetn = 1'b0;
   logic                           psel = 1'b0;
   logic                           penable = 1'b0;
   logic                           pwrite = 1'b0;
   logic [11:0]                    paddr = '0;
   logic [31:0]                    pwdata = '0;
   logic [31:0]                    prdata;
   logic                           pready;
   logic                           pslverr;
   logic [NUM_EP-1:0][NUM_FACTORS-1:0] ev_q = '0;
   logic                           doze = 1'b0;
   logic [1:0]                     bus_mode = 2'h0;
   logic                           se0, act, cdone, cres, go, hs, xrst, actv, auto, wake;
   logic [7:0]                     sum;
   logic [31:0]                    rd;
   logic                           err;
   int                             error_cnt = 0;
   int                             tests_run = 0;
   usbnr_row_type rows [7] = '{'{0, 8'h7F, 7'h01, 8'h01}, '{1, 8'h40, 7'h3F, 8'h00},
      '{2, 8'h40, 7'h40, 8'h04}, '{3, 8'h20, 7'h20, 8'h08}, '{4, 8'hFF, 7'h7F, 8'h10},
      '{5, 8'h04, 7'h7B, 8'h00}, '{7, 8'h01, 7'h01, 8'h80}};

   // Half period of 2 ns gives 250 MHz.
   always #2 pclk = ~pclk;

   usbnr_regs #(.ADDR_W(12), .IDLE_CYCLES(40), .SE0_CYCLES(8)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .endpoint_event_status(ev_q), .low_power_doze_state(doze), .line_active(act),
      .line_se0(se0), .chirp_done_in(cdone), .chirp_hs_result(cres),
      .endpoint_summary_irq_status(sum), .xcvr_macro_reset_bit(xrst),
      .controller_activate(actv), .auto_speed_negotiation_enable(auto),
      .remote_wake_signal(wake), .chirp_go(go), .hs_mode(hs));

   usbnr_host_model host_u (.pclk(pclk), .bus_mode(bus_mode), .chirp_go(go),
      .line_se0(se0), .line_active(act), .chirp_done_in(cdone), .chirp_hs_result(cres));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s exp %0h got %0h", what, exp, got);
      end
   endtask

   // One APB transfer; waits for pready as long as it takes, then lets one edge
   // pass so that a write has landed before the caller looks at the outputs.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      chk("read", exp, rd);
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // A full run is a few hundred cycles; the limit leaves a wide margin.
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      conclude();
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < NUM_EP; i++) rchk(IDX_EP_IRQ_EN[i], 32'h0);
      rchk(IDX_XCVR_RESET, 32'h1);
      rchk(IDX_NEGO_CTRL, 32'h0);
      chk("xcvr", 1, xrst);
      foreach (rows[r]) begin
         apb(1'b1, IDX_EP_IRQ_EN[rows[r].ep], rows[r].en);
         ev_q <= '1 & ~('1 << 0);
         ev_q[rows[r].ep] <= rows[r].ev;
         repeat (2) @(posedge pclk);
         chk("summary", rows[r].sum, sum);
         rchk(IDX_EP_IRQ_EN[rows[r].ep], rows[r].en & 8'h7F);
         apb(1'b1, IDX_EP_IRQ_EN[rows[r].ep], 8'h00);
         repeat (2) @(posedge pclk);
         chk("masked", 0, sum);
         ev_q <= '0;
      end
      apb(1'b1, IDX_XCVR_RESET, 8'h00);
      chk("xcvr", 0, xrst);
      doze <= 1'b1;
      apb(1'b1, IDX_NEGO_CTRL, 8'h01);
      apb(1'b1, IDX_XCVR_RESET, 8'h01);
      chk("xcvr", 1, xrst);
      rchk(IDX_XCVR_RESET, 32'h1);
      apb(1'b1, IDX_XCVR_RESET, 8'h00);
      chk("xcvr", 0, xrst);
      doze <= 1'b0;
      rchk(IDX_NEGO_CTRL, 32'h0);
      apb(1'b0, 8'h00, 8'h00);
      chk("slverr", 1, err);
      apb(1'b1, IDX_NEGO_CTRL, 8'h49);
      chk("nego", 3'b111, {auto, wake, actv});
      apb(1'b1, IDX_NEGO_CTRL, 8'h01);
      chk("activate", 3'b001, {auto, wake, actv});
      bus_mode <= 2'h1;
      repeat (12) @(posedge pclk);
      apb(1'b1, IDX_NEGO_CTRL, 8'h13);
      rchk(IDX_NEGO_CTRL, 32'h11);
      chk("hs refused", 0, hs);
      apb(1'b1, IDX_NEGO_CTRL, 8'h03);
      rd = 32'h2;
      for (int n = 0; n < 20 && rd[1] !== 1'b0; n++) apb(1'b0, IDX_NEGO_CTRL, 8'h00);
      chk("chirp clear", 32'h1, rd);
      chk("chirp go", 0, go);
      chk("hs", 1, hs);
      rchk(IDX_EVENT_FLAGS, 32'h3);
      bus_mode <= 2'h0;
      repeat (48) @(posedge pclk);
      chk("hs drop", 0, hs);
      apb(1'b1, IDX_NEGO_CTRL, 8'h05);
      rchk(IDX_EVENT_FLAGS, 32'hB);
      apb(1'b1, IDX_EVENT_FLAGS, 8'h0F);
      rchk(IDX_EVENT_FLAGS, 32'h0);
      repeat (30) @(posedge pclk);
      rchk(IDX_EVENT_FLAGS, 32'h4);
      // Reset again in mid-run, with an enable and the transceiver bit moved off reset.
      apb(1'b1, IDX_EP_IRQ_EN[6], 8'h7F);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk("xcvr", 1, xrst);
      rchk(IDX_EP_IRQ_EN[6], 32'h0);
      rchk(IDX_NEGO_CTRL, 32'h0);
      conclude();
   end
endmodule
